// ### rtl/bsf_pkg.sv
// Purpose: shared constants and types of the branch and skip flow unit
// Assumes: 16-bit word addressed program counter, 8-bit data
// Notes:   status flag bit order is C Z N V S H T I, bit 0 first
package bsf_pkg;

  // ---------------------------------------------------------------
  // status flag positions
  // ---------------------------------------------------------------
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] PC_RESET    = 16'h0000;
  localparam logic [7:0]  FLAGS_RESET = 8'h00;

  // ---------------------------------------------------------------
  // cycle counts
  // ---------------------------------------------------------------
  localparam logic [2:0] CYC_ONE          = 3'h1;
  localparam logic [2:0] CYC_PTR_JUMP     = 3'h2;
  localparam logic [2:0] CYC_PTR_CALL     = 3'h3;
  localparam logic [2:0] CYC_REL_JUMP     = 3'h2;
  localparam logic [2:0] CYC_REL_CALL     = 3'h3;
  localparam logic [2:0] CYC_DIR_JUMP     = 3'h3;
  localparam logic [2:0] CYC_DIR_CALL     = 3'h4;
  localparam logic [2:0] CYC_BRANCH_TAKEN = 3'h2;
  localparam logic [2:0] CYC_SKIP_ONE     = 3'h2;
  localparam logic [2:0] CYC_SKIP_TWO     = 3'h3;

  // ---------------------------------------------------------------
  // program counter steps
  // ---------------------------------------------------------------
  localparam logic [15:0] PC_STEP_ONE  = 16'h0001;
  localparam logic [15:0] PC_STEP_TWO  = 16'h0002;
  localparam logic [15:0] PC_SKIP_ONE  = 16'h0002;
  localparam logic [15:0] PC_SKIP_TWO  = 16'h0003;

  // ---------------------------------------------------------------
  // operations
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    op_none,
    pointer_jump, pointer_call, rel_jump, rel_call, direct_jump,
    direct_call, compare_skip_equal, compare_regs, compare_carry,
    compare_immediate, skip_reg_bit_clear, skip_reg_bit_set,
    skip_io_bit_clear, skip_io_bit_set, branch_flag_set,
    branch_flag_clear, branch_same_or_higher, branch_carry_clear,
    branch_signed_ge, branch_signed_lt, branch_halfcarry_set,
    branch_halfcarry_clear, branch_transfer_set, branch_transfer_clear
  } bsf_op_t;

  typedef struct packed {
    bsf_op_t     op;
    logic [15:0] pc;
    logic [15:0] ptr;
    logic [15:0] target;
    logic [11:0] offset;
    logic [7:0]  rd_val;
    logic [7:0]  rr_val;
    logic [7:0]  imm;
    logic [2:0]  bit_sel;
    logic        io_bit;
    logic        next_two_word;
  } bsf_req_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
  } bsf_push_t;

endpackage

// ### rtl/bsf_flow_unit.sv
// Purpose: jump, call, compare, skip and conditional branch execution
// Assumes: operands are read from the register file and I/O space
//          by the caller in the issue cycle, same clock domain
// Notes:   one request in flight; new issue accepted when not busy
//
// What this block does
// - pointer jump loads pc from pointer, two cycles, flags kept
// - pointer call goes to pointer address, three cycles, flags kept
// - compare skip equal adds two or three to pc when equal
// - compare immediate sets Z N V C H from difference, one cycle
// - skip when chosen register bit is zero, one to three cycles
// - skip when chosen register bit is one, one to three cycles
// - skip when addressed I/O bit reads zero, one to three cycles
// - skip when addressed I/O bit reads one, one to three cycles
// - branch adds offset plus one when selected flag is one
// - branch adds offset plus one when selected flag is zero
// - same-or-higher branch taken exactly when carry is zero
// - signed greater-or-equal taken when N xor V is zero
// - signed less-than taken when N xor V is one
// - half-carry-set branch taken when H is one
// - half-carry-clear branch taken when H is zero
// - transfer-set branch taken when T is one
// - transfer-clear branch taken when T is zero
// - carry-clear branch behaves the same as same-or-higher
`timescale 1ns/10ps

module bsf_flow_unit
  import bsf_pkg::*;
#(
  parameter int CNT_W = 3
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic        issue,
  input  wire bsf_req_t    req,
  input  wire logic [7:0]  status_flags_register,
  output logic             busy,
  output logic             done,
  output logic             pc_load,
  output logic [15:0]      pc_out,
  output logic             flags_we,
  output logic [7:0]       flags_out,
  output bsf_push_t        push
);

  // ---------------------------------------------------------------
  // elaboration check
  // ---------------------------------------------------------------
  generate
    if (CNT_W < 3) begin : g_bad_cnt
      $error("CNT_W must hold the longest cycle count");
    end
  endgenerate

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  typedef enum logic {st_idle, st_run} bsf_state_t;

  bsf_state_t        state;
  logic [CNT_W-1:0]  remain;
  logic              take;
  logic [15:0]       pc_seq;
  logic [15:0]       pc_rel;
  logic [15:0]       pc_skip;
  logic [7:0]        rr_bits;
  logic              cond;
  logic              skip_hit;
  logic              br_hit;
  logic [7:0]        cmp_a;
  logic [7:0]        cmp_b;
  logic              cmp_cin;
  logic [7:0]        cmp_res;
  logic [7:0]        cmp_flags;
  logic [7:0]        flag_sel;
  logic [15:0]       next_pc;
  logic [CNT_W-1:0]  next_cycles;
  logic              next_flags_we;
  logic [7:0]        next_flags;
  logic              next_push;
  logic [15:0]       next_push_addr;
  logic [15:0]       pc_hold;
  logic              flags_hold;
  logic [7:0]        flags_val;

  assign take = ce && issue && (state == st_idle);

  // ---------------------------------------------------------------
  // address arithmetic
  // ---------------------------------------------------------------
  assign pc_seq  = req.pc + PC_STEP_ONE;
  assign pc_rel  = req.pc + {{4{req.offset[11]}}, req.offset}
                 + PC_STEP_ONE;
  assign pc_skip = req.next_two_word ? (req.pc + PC_SKIP_TWO)
                                     : (req.pc + PC_SKIP_ONE);

  // ---------------------------------------------------------------
  // bit select per bit of the tested register and of the status flags
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_bit
      assign rr_bits[gi] = req.rr_val[gi]
                        && (req.bit_sel == 3'(gi));
      assign flag_sel[gi] = status_flags_register[gi]
                         && (req.bit_sel == 3'(gi));
    end
  endgenerate

  // ---------------------------------------------------------------
  // compare arithmetic, result discarded
  // ---------------------------------------------------------------
  always_comb begin
    cmp_a   = req.rd_val;
    cmp_b   = (req.op == compare_immediate) ? req.imm : req.rr_val;
    cmp_cin = (req.op == compare_carry)
            ? status_flags_register[FLAG_C] : 1'b0;
  end

  assign cmp_res = cmp_a - cmp_b - {7'h00, cmp_cin};

  always_comb begin
    cmp_flags         = status_flags_register;
    cmp_flags[FLAG_C] = (~cmp_a[7] & cmp_b[7]) | (cmp_b[7] & cmp_res[7])
                      | (cmp_res[7] & ~cmp_a[7]);
    cmp_flags[FLAG_H] = (~cmp_a[3] & cmp_b[3]) | (cmp_b[3] & cmp_res[3])
                      | (cmp_res[3] & ~cmp_a[3]);
    cmp_flags[FLAG_V] = (cmp_a[7] & ~cmp_b[7] & ~cmp_res[7])
                      | (~cmp_a[7] & cmp_b[7] & cmp_res[7]);
    cmp_flags[FLAG_N] = cmp_res[7];
    // compare with carry keeps zero only across a zero chain
    if (req.op == compare_carry) begin
      cmp_flags[FLAG_Z] = (cmp_res == 8'h00)
                        && status_flags_register[FLAG_Z];
    end else begin
      cmp_flags[FLAG_Z] = (cmp_res == 8'h00);
    end
  end

  // ---------------------------------------------------------------
  // skip and branch conditions
  // ---------------------------------------------------------------
  always_comb begin
    skip_hit = 1'b0;
    unique case (req.op)
      compare_skip_equal: skip_hit = (req.rd_val == req.rr_val);
      skip_reg_bit_clear: skip_hit = ~(|rr_bits);
      skip_reg_bit_set:   skip_hit = |rr_bits;
      skip_io_bit_clear:  skip_hit = ~req.io_bit;
      skip_io_bit_set:    skip_hit = req.io_bit;
      default:            skip_hit = 1'b0;
    endcase
  end

  always_comb begin
    cond = 1'b0;
    unique case (req.op)
      branch_flag_set:        cond = |flag_sel;
      branch_flag_clear:      cond = ~(|flag_sel);
      branch_same_or_higher:  cond = ~status_flags_register[FLAG_C];
      branch_carry_clear:     cond = ~status_flags_register[FLAG_C];
      branch_signed_ge:       cond = ~(status_flags_register[FLAG_N]
                                     ^ status_flags_register[FLAG_V]);
      branch_signed_lt:       cond = status_flags_register[FLAG_N]
                                   ^ status_flags_register[FLAG_V];
      branch_halfcarry_set:   cond = status_flags_register[FLAG_H];
      branch_halfcarry_clear: cond = ~status_flags_register[FLAG_H];
      branch_transfer_set:    cond = status_flags_register[FLAG_T];
      branch_transfer_clear:  cond = ~status_flags_register[FLAG_T];
      default:                cond = 1'b0;
    endcase
  end

  assign br_hit = cond;

  // ---------------------------------------------------------------
  // outcome of the request
  // ---------------------------------------------------------------
  always_comb begin
    next_pc        = pc_seq;
    next_cycles    = CNT_W'(CYC_ONE);
    next_flags_we  = 1'b0;
    next_flags     = status_flags_register;
    next_push      = 1'b0;
    next_push_addr = pc_seq;
    unique case (req.op)
      op_none: begin
        next_pc = pc_seq;
      end
      pointer_jump: begin
        next_pc     = req.ptr;
        next_cycles = CNT_W'(CYC_PTR_JUMP);
      end
      pointer_call: begin
        next_pc     = req.ptr;
        next_cycles = CNT_W'(CYC_PTR_CALL);
        next_push   = 1'b1;
      end
      rel_jump: begin
        next_pc     = pc_rel;
        next_cycles = CNT_W'(CYC_REL_JUMP);
      end
      rel_call: begin
        next_pc     = pc_rel;
        next_cycles = CNT_W'(CYC_REL_CALL);
        next_push   = 1'b1;
      end
      direct_jump: begin
        next_pc     = req.target;
        next_cycles = CNT_W'(CYC_DIR_JUMP);
      end
      // two-word call returns past both words
      direct_call: begin
        next_pc        = req.target;
        next_cycles    = CNT_W'(CYC_DIR_CALL);
        next_push      = 1'b1;
        next_push_addr = req.pc + PC_STEP_TWO;
      end
      compare_regs, compare_carry, compare_immediate: begin
        next_flags_we = 1'b1;
        next_flags    = cmp_flags;
      end
      compare_skip_equal, skip_reg_bit_clear, skip_reg_bit_set,
      skip_io_bit_clear, skip_io_bit_set: begin
        if (skip_hit) begin
          next_pc     = pc_skip;
          next_cycles = req.next_two_word ? CNT_W'(CYC_SKIP_TWO)
                                          : CNT_W'(CYC_SKIP_ONE);
        end
      end
      branch_flag_set, branch_flag_clear, branch_same_or_higher,
      branch_carry_clear, branch_signed_ge, branch_signed_lt,
      branch_halfcarry_set, branch_halfcarry_clear,
      branch_transfer_set, branch_transfer_clear: begin
        if (br_hit) begin
          next_pc     = pc_rel;
          next_cycles = CNT_W'(CYC_BRANCH_TAKEN);
        end
      end
      default: next_pc = pc_seq;
    endcase
  end

  // ---------------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state  <= st_idle;
      remain <= '0;
      busy   <= 1'b0;
    end else if (ce) begin
      unique case (state)
        st_idle: begin
          if (take) begin
            state  <= st_run;
            remain <= next_cycles;
            busy   <= 1'b1;
          end
        end
        st_run: begin
          remain <= remain - CNT_W'(1);
          if (remain == CNT_W'(1)) begin
            state <= st_idle;
            busy  <= 1'b0;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // completion and pc result
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pc_hold <= PC_RESET;
    end else if (take) begin
      pc_hold <= next_pc;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      done    <= 1'b0;
      pc_load <= 1'b0;
      pc_out  <= PC_RESET;
    end else if (ce) begin
      done    <= 1'b0;
      pc_load <= 1'b0;
      if (state == st_run && remain == CNT_W'(1)) begin
        done    <= 1'b1;
        pc_load <= 1'b1;
        pc_out  <= pc_hold;
      end
    end
  end

  // ---------------------------------------------------------------
  // status flags, written only by compares
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flags_hold <= 1'b0;
      flags_val  <= FLAGS_RESET;
    end else if (take) begin
      flags_hold <= next_flags_we;
      flags_val  <= next_flags;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flags_we  <= 1'b0;
      flags_out <= FLAGS_RESET;
    end else if (ce) begin
      flags_we <= 1'b0;
      if (state == st_run && remain == CNT_W'(1) && flags_hold) begin
        flags_we  <= 1'b1;
        flags_out <= flags_val;
      end
    end
  end

  // ---------------------------------------------------------------
  // return address push, one cycle after issue
  // ---------------------------------------------------------------
  // push ahead of pc load
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      push <= '0;
    end else if (ce) begin
      push.valid <= take && next_push;
      if (take && next_push) begin
        push.addr <= next_push_addr;
      end
    end
  end

endmodule

// ### dv/bsf_flow_unit_props.sv
// Purpose: concurrent checks on the ports of the flow unit
// Assumes: attempts that span a low ce are dropped, ce freezes all
// Notes:   bound onto every bsf_flow_unit instance
`timescale 1ns/10ps

module bsf_flow_unit_props
  import bsf_pkg::*;
#(
  parameter int CNT_W = 3
) (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        ce,
  input wire logic        issue,
  input wire bsf_req_t    req,
  input wire logic [7:0]  status_flags_register,
  input wire logic        busy,
  input wire logic        done,
  input wire logic        pc_load,
  input wire logic [15:0] pc_out,
  input wire logic        flags_we,
  input wire logic [7:0]  flags_out,
  input wire bsf_push_t   push
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn || !ce);
  wire take = ce & issue & ~busy;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_done_pulse: assert property (done |=> !done)
    else $error("done lasted more than one cycle");
  a_done_loads: assert property (done |-> pc_load && !busy)
    else $error("done without pc load or while busy");
  a_busy_ends: assert property ($fell(busy) |-> done)
    else $error("busy fell without done");
  a_take_busy: assert property (take |=> busy)
    else $error("take did not raise busy");
  a_jump_target: assert property (
    take && req.op == pointer_jump |->
      ##3 done && !flags_we && pc_out == $past(req.ptr, 3))
    else $error("pointer jump target or timing wrong");
  a_call_push: assert property (
    take && req.op == pointer_call |=>
      push.valid && push.addr == $past(req.pc) + 16'h0001)
    else $error("pointer call return address wrong");
  a_call_cycles: assert property (
    take && req.op == pointer_call |-> ##1 busy [*3] ##1 done)
    else $error("pointer call cycle count wrong");
  a_cmp_zero: assert property (
    take && req.op == compare_immediate |-> ##2 flags_we &&
      flags_out[FLAG_Z] == ($past(req.rd_val, 2) == $past(req.imm, 2)))
    else $error("compare immediate zero flag wrong");
  a_branch_fall: assert property (
    take && req.op == branch_flag_set &&
      !status_flags_register[req.bit_sel] |->
      ##2 done && pc_out == $past(req.pc, 2) + 16'h0001)
    else $error("untaken branch pc wrong");
  a_skip_noflag: assert property (
    take && req.op inside {skip_reg_bit_clear, skip_reg_bit_set,
      skip_io_bit_clear, skip_io_bit_set, compare_skip_equal} |->
      ##1 !flags_we [*3])
    else $error("skip wrote flags");
endmodule

bind bsf_flow_unit bsf_flow_unit_props #(.CNT_W(CNT_W)) props_inst (
  .clk(clk), .rstn(rstn), .ce(ce), .issue(issue), .req(req),
  .status_flags_register(status_flags_register), .busy(busy),
  .done(done), .pc_load(pc_load), .pc_out(pc_out),
  .flags_we(flags_we), .flags_out(flags_out), .push(push)
);

// ### dv/tb_top.sv
// Purpose: self-checking bench for the flow unit
// Assumes: all instructions sit at one address, ce held high except in the clock enable test
// Notes:   rows run back to back; done seen in the cycle busy falls
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin \
  n_checks++; \
  if ((got) !== (ex)) begin \
    errors++; \
    $display("ERROR %s expected %h seen %h", nm, ex, got); \
  end \
end

module tb_top
  import bsf_pkg::*;
;
  typedef struct {
    bsf_op_t     op;
    logic [11:0] x;
    logic [15:0] y;
    logic [4:0]  m;
    logic [7:0]  fl;
    logic [11:0] epc;
    int          n;
  } bsf_row_t;

  localparam logic [15:0] PC0 = 16'h0050;

  logic        clk, rstn, ce, issue, busy, done, pc_load, flags_we;
  logic [7:0]  status_flags_register, flags_out;
  logic [15:0] pc_out;
  bsf_req_t    req;
  bsf_push_t   push;
  int          errors, n_checks;
  bsf_row_t    rows[$];

  bsf_flow_unit #(.CNT_W(3)) bsf_flow_unit_inst (
    .clk(clk), .rstn(rstn), .ce(ce), .issue(issue), .req(req),
    .status_flags_register(status_flags_register), .busy(busy),
    .done(done), .pc_load(pc_load), .pc_out(pc_out),
    .flags_we(flags_we), .flags_out(flags_out), .push(push)
  );

  always #50 clk = ~clk;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic void r(bsf_op_t op, logic [11:0] x,
                            logic [15:0] y, logic [4:0] m,
                            logic [7:0] fl, logic [11:0] epc, int n);
    rows.push_back('{op, x, y, m, fl, epc, n});
  endfunction

  function automatic logic [7:0] cmp_fl(logic [7:0] fl, rd, k, logic cy);
    logic [8:0] d;
    logic [4:0] h;
    logic       cin;
    cin = cy & fl[FLAG_C];
    d = {1'h0, rd} - {1'h0, k} - {8'h00, cin};
    h = {1'h0, rd[3:0]} - {1'h0, k[3:0]} - {4'h0, cin};
    cmp_fl = fl;
    cmp_fl[FLAG_C] = d[8];
    cmp_fl[FLAG_Z] = (d[7:0] == 8'h00) & (~cy | fl[FLAG_Z]);
    cmp_fl[FLAG_N] = d[7];
    cmp_fl[FLAG_V] = (rd[7] ^ k[7]) & (rd[7] ^ d[7]);
    cmp_fl[FLAG_H] = h[4];
  endfunction

  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // entered and left at a falling edge; left in the done cycle
  task automatic run(bsf_row_t t);
    int          cyc;
    logic        pv;
    logic [15:0] pa;
    logic        is_cmp;
    logic        is_call;
    logic [7:0]  ef;
    logic [15:0] pstep;
    pv = 1'h0;
    pa = 16'h0000;
    is_cmp = t.op inside {compare_regs, compare_carry, compare_immediate};
    is_call = t.op inside {pointer_call, rel_call, direct_call};
    ef = cmp_fl(t.fl, t.y[15:8], t.y[7:0], t.op == compare_carry);
    pstep = (t.op == direct_call) ? 16'h0002 : 16'h0001;
    req = '{t.op, PC0, {4'h0, t.x}, {4'h0, t.x}, t.x, t.y[15:8],
            t.y[7:0], t.y[7:0], t.m[4:2], t.m[1], t.m[0]};
    status_flags_register = t.fl;
    issue = 1'h1;
    @(negedge clk);
    issue = 1'h0;
    cyc = 1;
    while (done !== 1'h1 && cyc < 9) begin
      if (push.valid === 1'h1) begin
        pv = 1'h1;
        pa = push.addr;
      end
      @(negedge clk);
      cyc++;
    end
    `CHK("cycles", t.n + 1, cyc)
    `CHK("pc_out", {4'h0, t.epc}, pc_out)
    `CHK("pc_load", 1'h1, pc_load)
    `CHK("flags_we", is_cmp, flags_we)
    if (is_cmp)
      `CHK("flags_out", ef, flags_out)
    `CHK("push", is_call, pv)
    if (pv)
      `CHK("push_addr", PC0 + pstep, pa)
  endtask

  // ------------------------------------------------------------
  // watchdog: whole run needs well under two thousand cycles
  // ------------------------------------------------------------
  initial begin
    #200000;
    errors++;
    end_of_test();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    clk = 1'h0;
    rstn = 1'h0;
    ce = 1'h1;
    issue = 1'h0;
    req = '0;
    status_flags_register = 8'h00;
    errors = 0;
    n_checks = 0;
    repeat (2) @(negedge clk);
    rstn = 1'h1;
    `CHK("rst_busy", 1'h0, busy)
    `CHK("rst_done", 1'h0, done)
    `CHK("rst_pc", 16'h0000, pc_out)
    `CHK("rst_flags", 8'h00, flags_out)
    $display("test reset done");
    r(pointer_jump,12'h123,16'h0000,5'h00,8'hFF,12'h123,2);
    r(pointer_call,12'h100,16'h0000,5'h00,8'hFF,12'h100,3);
    r(compare_skip_equal,12'h000,16'h5555,5'h00,8'h00,12'h052,2);
    r(compare_skip_equal,12'h000,16'h5555,5'h01,8'h00,12'h053,3);
    r(compare_skip_equal,12'h000,16'h5556,5'h01,8'h00,12'h051,1);
    r(compare_immediate,12'h000,16'h1020,5'h00,8'hFF,12'h051,1);
    r(compare_immediate,12'h000,16'h8001,5'h00,8'h00,12'h051,1);
    r(compare_immediate,12'h000,16'h1001,5'h00,8'h00,12'h051,1);
    r(compare_immediate,12'h000,16'h4242,5'h00,8'h00,12'h051,1);
    r(skip_reg_bit_clear,12'h000,16'hF7F7,5'h0D,8'h00,12'h053,3);
    r(skip_reg_bit_clear,12'h000,16'h0808,5'h0C,8'h00,12'h051,1);
    r(skip_reg_bit_set,12'h000,16'h0808,5'h0C,8'h00,12'h052,2);
    r(skip_reg_bit_set,12'h000,16'hF7F7,5'h0C,8'h00,12'h051,1);
    r(skip_io_bit_clear,12'h000,16'h0000,5'h00,8'h00,12'h052,2);
    r(skip_io_bit_clear,12'h000,16'h0000,5'h02,8'h00,12'h051,1);
    r(skip_io_bit_set,12'h000,16'h0000,5'h03,8'h00,12'h053,3);
    r(skip_io_bit_set,12'h000,16'h0000,5'h00,8'h00,12'h051,1);
    r(branch_flag_set,12'h005,16'h0000,5'h18,8'h40,12'h056,2);
    r(branch_flag_set,12'h005,16'h0000,5'h18,8'hBF,12'h051,1);
    r(branch_flag_clear,12'hFFE,16'h0000,5'h00,8'h00,12'h04F,2);
    r(branch_flag_clear,12'hFFE,16'h0000,5'h00,8'h01,12'h051,1);
    r(branch_same_or_higher,12'h003,16'h0000,5'h00,8'h00,12'h054,2);
    r(branch_same_or_higher,12'h003,16'h0000,5'h00,8'h01,12'h051,1);
    r(branch_carry_clear,12'h003,16'h0000,5'h00,8'h00,12'h054,2);
    r(branch_carry_clear,12'h003,16'h0000,5'h00,8'h01,12'h051,1);
    r(branch_signed_ge,12'h003,16'h0000,5'h00,8'h0C,12'h054,2);
    r(branch_signed_ge,12'h003,16'h0000,5'h00,8'h04,12'h051,1);
    r(branch_signed_lt,12'h003,16'h0000,5'h00,8'h08,12'h054,2);
    r(branch_signed_lt,12'h003,16'h0000,5'h00,8'h0C,12'h051,1);
    r(branch_halfcarry_set,12'h003,16'h0000,5'h00,8'h20,12'h054,2);
    r(branch_halfcarry_set,12'h003,16'h0000,5'h00,8'h00,12'h051,1);
    r(branch_halfcarry_clear,12'h003,16'h0000,5'h00,8'h00,12'h054,2);
    r(branch_halfcarry_clear,12'h003,16'h0000,5'h00,8'h20,12'h051,1);
    r(branch_transfer_set,12'h003,16'h0000,5'h00,8'h40,12'h054,2);
    r(branch_transfer_clear,12'h003,16'h0000,5'h00,8'h00,12'h054,2);
    r(branch_transfer_clear,12'h003,16'h0000,5'h00,8'h40,12'h051,1);
    r(rel_jump,12'h003,16'h0000,5'h00,8'h00,12'h054,2);
    r(rel_call,12'h003,16'h0000,5'h00,8'h00,12'h054,3);
    r(direct_jump,12'h200,16'h0000,5'h00,8'h00,12'h200,3);
    r(direct_call,12'h200,16'h0000,5'h00,8'h00,12'h200,4);
    r(compare_regs,12'h000,16'h1020,5'h00,8'h00,12'h051,1);
    r(compare_carry,12'h000,16'h1110,5'h00,8'h03,12'h051,1);
    r(compare_carry,12'h000,16'h1110,5'h00,8'h01,12'h051,1);
    r(op_none,12'h000,16'h0000,5'h00,8'h00,12'h051,1);
    foreach (rows[i]) begin
      run(rows[i]);
      $display("test row %0d done", i);
    end
    // issue held high while busy must be ignored
    req = '{pointer_call, PC0, 16'h0300, 16'h0300, 12'h300, 8'h00,
            8'h00, 8'h00, 3'h0, 1'h0, 1'h0};
    issue = 1'h1;
    @(negedge clk);
    req.op = pointer_jump;
    req.ptr = 16'h0500;
    repeat (2) @(negedge clk);
    issue = 1'h0;
    @(negedge clk);
    `CHK("held_done", 1'h1, done)
    `CHK("held_pc", 16'h0300, pc_out)
    @(negedge clk);
    `CHK("held_idle", 1'h0, busy)
    $display("test busy ignore done");
    // reset in mid call, then recover
    req.op = pointer_call;
    issue = 1'h1;
    @(negedge clk);
    issue = 1'h0;
    @(negedge clk);
    rstn = 1'h0;
    #1;
    `CHK("mid_busy", 1'h0, busy)
    `CHK("mid_pc", 16'h0000, pc_out)
    @(negedge clk);
    rstn = 1'h1;
    run(rows[0]);
    $display("test mid reset done");
    // low clock enable freezes a running jump
    req.ptr = 16'h0456;
    issue = 1'h1;
    @(negedge clk);
    issue = 1'h0;
    ce = 1'h0;
    repeat (3) @(negedge clk);
    `CHK("ce_busy", 1'h1, busy)
    `CHK("ce_done", 1'h0, done)
    ce = 1'h1;
    repeat (2) @(negedge clk);
    `CHK("ce_done_late", 1'h1, done)
    `CHK("ce_pc", 16'h0456, pc_out)
    $display("test clock enable done");
    end_of_test();
  end
endmodule
